/* File: wakeup_poc_defines.vh */
`ifndef WAKEUP_POC_DEFINES_VH
`define WAKEUP_POC_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ADR_COMMAND 8'h00
`define ADR_CTRL_STATUS 8'h04
`define ADR_STATUS_IRQ 8'h08
`define ADR_STATUS_CLR 8'h0C
`define ADR_IRQ_ENABLE 8'h10
`define ADR_OFFSET_LIMIT 8'h14

// ****************************************
// Host commands
// ****************************************
`define CMD_W 4
`define CMD_NONE 4'h0
`define CMD_READY 4'h1
`define CMD_WAKEUP 4'h2
`define CMD_RUN 4'h3
`define CMD_ALLOW_CS 4'h4

// ****************************************
// Status and interrupt bits
// ****************************************
`define IRQ_W 5
`define IRQ_WAKEUP_ST 0
`define IRQ_WUP_A 1
`define IRQ_WUP_B 2
`define IRQ_NORMAL 3
`define IRQ_ABORT 4

// ****************************************
// Controller status vector fields
// ****************************************
`define CSV_STATE_LSB 0
`define CSV_STATE_MSB 4
`define CSV_CSI 8
`define CSV_WSV_LSB 12
`define CSV_WSV_MSB 14
`define WSV_UNDEFINED 3'h0
`define WSV_RX_WUP 3'h3

// ****************************************
// Timing and widths
// ****************************************
`define SCHED_INIT_MT 8'h08
`define OFFSET_W 16
`define OFFSET_LIMIT_RST 16'h0100

`endif

/* File: wus_pattern_detector.v */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Wakeup pattern detector, one channel
// ****************************************
module wus_pattern_detector (
  input wire clk_i,
  input wire rst_i,
  input wire wus_i,
  input wire gap_ok_i,
  output reg wup_o
);

  reg half_q;

  // No blanking by controller state, so a symbol right after a state
  // change still counts
  always @(posedge clk_i) begin
    if (rst_i) begin
      half_q <= 1'b0;
      wup_o <= 1'b0;
    end else begin
      wup_o <= 1'b0;
      if (wus_i) begin
        if (half_q && gap_ok_i) begin
          wup_o <= 1'b1;
          half_q <= 1'b0;
        end else begin
          half_q <= 1'b1;
        end
      end
    end
  end

endmodule // wus_pattern_detector

`default_nettype wire

/* File: integration_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_poc_defines.vh"

// ****************************************
// Schedule initialisation and cycle offset check
// ****************************************
module integration_ctrl (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire abort_i,
  input wire mt_tick_i,
  input wire pair_end_i,
  input wire [`OFFSET_W-1:0] offset_i,
  input wire [`OFFSET_W-1:0] limit_i,
  output reg done_o,
  output reg fail_o,
  output reg [`OFFSET_W-1:0] corr_o
);

  localparam S_IDLE = 4'b0001;
  localparam S_ALIGN = 4'b0010;
  localparam S_INIT = 4'b0100;
  localparam S_CHECK = 4'b1000;

  reg [3:0] state_q;
  reg [7:0] mt_cnt_q;
  wire [`OFFSET_W-1:0] mag;

  assign mag = offset_i[`OFFSET_W-1] ? (~offset_i + 16'h0001) : offset_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      mt_cnt_q <= 8'h00;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      corr_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
      if (abort_i) begin
        state_q <= S_IDLE;
        mt_cnt_q <= 8'h00;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (start_i) begin
              state_q <= S_ALIGN;
              mt_cnt_q <= 8'h00;
            end
          end
          // A partial macrotick at start never counts toward the length
          S_ALIGN: begin
            if (mt_tick_i) begin
              state_q <= S_INIT;
            end
          end
          S_INIT: begin
            if (mt_tick_i) begin
              if (mt_cnt_q == `SCHED_INIT_MT - 8'h01) begin
                state_q <= S_CHECK;
              end else begin
                mt_cnt_q <= mt_cnt_q + 8'h01;
              end
            end
          end
          S_CHECK: begin
            if (pair_end_i) begin
              state_q <= S_IDLE;
              if (mag < limit_i) begin
                done_o <= 1'b1;
                corr_o <= offset_i;
              end else begin
                fail_o <= 1'b1;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // integration_ctrl

`default_nettype wire

/* File: wakeup_poc_ctrl.v */
// What this block does
// - Valid wakeup pattern when a symbol with gap_ok set follows a pending first symbol
// - Every wakeup symbol counted, also after listen
// - Wakeup in listen: READY, vector, flags set
// - Channel flags set at second symbol
// - READY command in READY is ignored
// - Each entry to READY sets coldstart inhibit
// - READY command aborts startup or normal operation
// - Schedule initialisation keeps full length
// - Offset computed after first cycle pair
// - Large limit: offset corrected, reach normal
// - Small limit: abort startup, then retry
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_poc_defines.vh"

module wakeup_poc_ctrl (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire wus_a_i,
  input wire wus_b_i,
  input wire gap_ok_a_i,
  input wire gap_ok_b_i,
  input wire mt_tick_i,
  input wire pair_end_i,
  input wire [`OFFSET_W-1:0] offset_i,
  output reg irq_o,
  output reg [4:0] poc_state_o,
  output reg [`OFFSET_W-1:0] offset_corr_o
);

  // ****************************************
  // Controller states
  // ****************************************
  localparam S_READY = 5'b00001;
  localparam S_LISTEN = 5'b00010;
  localparam S_STARTUP = 5'b00100;
  localparam S_NORMAL = 5'b01000;
  localparam S_ABORT = 5'b10000;

  // ****************************************
  // Byte lane mask from Wishbone select
  // ****************************************
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // ****************************************
  // Write strobe for one register offset
  // ****************************************
  function wr_hit;
    input go;
    input [7:0] adr;
    input [7:0] target;
    begin
      wr_hit = go && (adr == target);
    end
  endfunction

  // ****************************************
  // Controller status vector layout
  // ****************************************
  function [31:0] csv_word;
    input [4:0] st;
    input csi;
    input [2:0] wsv;
    begin
      csv_word = 32'h00000000;
      csv_word[`CSV_STATE_MSB:`CSV_STATE_LSB] = st;
      csv_word[`CSV_CSI] = csi;
      csv_word[`CSV_WSV_MSB:`CSV_WSV_LSB] = wsv;
    end
  endfunction

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg csi_q;
  reg [2:0] wsv_q;
  reg [`IRQ_W-1:0] sir_q;
  reg [`IRQ_W-1:0] sir_d;
  reg [`IRQ_W-1:0] ien_q;
  reg [`OFFSET_W-1:0] limit_q;
  reg [`CMD_W-1:0] cmd;
  reg [`IRQ_W-1:0] clr;
  reg [`IRQ_W-1:0] set;
  reg start;
  reg leave;
  wire wr_go;
  wire [31:0] wmask;
  wire [1:0] wus;
  wire [1:0] gap_ok;
  wire [1:0] wup;
  wire int_done;
  wire int_fail;
  wire [`OFFSET_W-1:0] int_corr;

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Writes act on the edge where the master samples ack
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wmask = lane_mask(wb_sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          `ADR_CTRL_STATUS: begin
            wb_dat_o <= csv_word(state_q, csi_q, wsv_q);
          end
          `ADR_STATUS_IRQ: begin
            wb_dat_o <= {27'h0000000, sir_q};
          end
          `ADR_IRQ_ENABLE: begin
            wb_dat_o <= {27'h0000000, ien_q};
          end
          `ADR_OFFSET_LIMIT: begin
            wb_dat_o <= {16'h0000, limit_q};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  // Command and clear strobes last the single write edge
  always @* begin
    cmd = `CMD_NONE;
    clr = {`IRQ_W{1'b0}};
    if (wr_hit(wr_go, wb_adr_i, `ADR_COMMAND) && wb_sel_i[0]) begin
      cmd = wb_dat_i[`CMD_W-1:0];
    end
    if (wr_hit(wr_go, wb_adr_i, `ADR_STATUS_CLR)) begin
      clr = wb_dat_i[`IRQ_W-1:0] & wmask[`IRQ_W-1:0];
    end
  end

  // ****************************************
  // Host registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ien_q <= {`IRQ_W{1'b0}};
      limit_q <= `OFFSET_LIMIT_RST;
    end else if (wr_go) begin
      if (wb_adr_i == `ADR_IRQ_ENABLE) begin
        ien_q <= (ien_q & ~wmask[`IRQ_W-1:0]) | (wb_dat_i[`IRQ_W-1:0] & wmask[`IRQ_W-1:0]);
      end
      // Limit should exceed one macrotick with clock deviation margin
      if (wb_adr_i == `ADR_OFFSET_LIMIT) begin
        limit_q <= (limit_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
    end
  end

  // ****************************************
  // Wakeup detection per channel
  // ****************************************
  assign wus = {wus_b_i, wus_a_i};
  assign gap_ok = {gap_ok_b_i, gap_ok_a_i};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wus_pattern_detector u_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wus_i(wus[ch]),
        .gap_ok_i(gap_ok[ch]),
        .wup_o(wup[ch])
      );
    end
  endgenerate

  // ****************************************
  // Integration
  // ****************************************
  integration_ctrl u_integ (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start),
    .abort_i(leave),
    .mt_tick_i(mt_tick_i),
    .pair_end_i(pair_end_i),
    .offset_i(offset_i),
    .limit_i(limit_q),
    .done_o(int_done),
    .fail_o(int_fail),
    .corr_o(int_corr)
  );

  // ****************************************
  // Protocol operation controller
  // ****************************************
  always @* begin
    state_d = state_q;
    start = 1'b0;
    leave = 1'b0;
    case (state_q)
      S_READY: begin
        // READY here falls through with no action at all
        if (cmd == `CMD_WAKEUP) begin
          state_d = S_LISTEN;
        end else if (cmd == `CMD_RUN) begin
          state_d = S_STARTUP;
          start = 1'b1;
        end
      end
      S_LISTEN: begin
        if (cmd == `CMD_READY) begin
          state_d = S_READY;
        end else if (|wup) begin
          state_d = S_READY;
        end
      end
      S_STARTUP: begin
        if (cmd == `CMD_READY) begin
          state_d = S_READY;
          leave = 1'b1;
        end else if (int_done) begin
          state_d = S_NORMAL;
        end else if (int_fail) begin
          state_d = S_ABORT;
        end
      end
      S_NORMAL: begin
        if (cmd == `CMD_READY) begin
          state_d = S_READY;
        end
      end
      S_ABORT: begin
        state_d = S_STARTUP;
        start = 1'b1;
      end
      default: begin
        state_d = S_READY;
      end
    endcase
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always @* begin
    set = {`IRQ_W{1'b0}};
    set[`IRQ_WUP_A] = wup[0];
    set[`IRQ_WUP_B] = wup[1];
    set[`IRQ_WAKEUP_ST] = (state_q == S_LISTEN) && (|wup) && (cmd != `CMD_READY);
    set[`IRQ_NORMAL] = (state_q == S_STARTUP) && (state_d == S_NORMAL);
    set[`IRQ_ABORT] = (state_q == S_STARTUP) && (state_d == S_ABORT);
    // A new event beats a clear in the same cycle
    sir_d = (sir_q & ~clr) | set;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_READY;
      csi_q <= 1'b1;
      wsv_q <= `WSV_UNDEFINED;
      sir_q <= {`IRQ_W{1'b0}};
      irq_o <= 1'b0;
      poc_state_o <= S_READY;
      offset_corr_o <= 16'h0000;
    end else begin
      state_q <= state_d;
      poc_state_o <= state_d;
      sir_q <= sir_d;
      irq_o <= |(sir_d & ien_q);
      if (set[`IRQ_WAKEUP_ST]) begin
        wsv_q <= `WSV_RX_WUP;
      end
      if (state_d == S_READY && state_q != S_READY) begin
        csi_q <= 1'b1;
      end else if (cmd == `CMD_ALLOW_CS && state_q == S_READY) begin
        csi_q <= 1'b0;
      end
      if (int_done) begin
        offset_corr_o <= int_corr;
      end
    end
  end

endmodule // wakeup_poc_ctrl

`default_nettype wire

/* File: wakeup_poc_ctrl_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_poc_defines.vh"
// ****
// Port checks for the wakeup and POC controller
// ****
module wakeup_poc_ctrl_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wus_a_i,
  input wire logic wus_b_i,
  input wire logic gap_ok_a_i,
  input wire logic gap_ok_b_i,
  input wire logic mt_tick_i,
  input wire logic pair_end_i,
  input wire logic [4:0] poc_state_o
);
  // Pending first symbol per channel, tracked in every state
  logic par_a_q;
  logic par_b_q;
  logic [7:0] tick_q;
  wire cmd_rdy = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
    & (wb_adr_i == `ADR_COMMAND) & (wb_dat_i[3:0] == `CMD_READY);
  always @(posedge clk_i) begin
    if (rst_i) begin
      par_a_q <= 1'b0;
      par_b_q <= 1'b0;
      tick_q <= 8'h00;
    end else begin
      if (wus_a_i) par_a_q <= gap_ok_a_i ? ~par_a_q : 1'b1;
      if (wus_b_i) par_b_q <= gap_ok_b_i ? ~par_b_q : 1'b1;
      // Saturates so a stalled startup cannot wrap back to a small count
      if (poc_state_o != 5'h04) tick_q <= 8'h00;
      else if (mt_tick_i && tick_q != 8'hFF) tick_q <= tick_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  a_ready_cmd: assert property (cmd_rdy |=> poc_state_o == 5'h01)
    else $error("ready command did not leave the controller in ready");
  a_listen_wakeup: assert property (poc_state_o == 5'h02 && wus_a_i && gap_ok_a_i
    && par_a_q |-> ##[1:3] poc_state_o == 5'h01)
    else $error("wakeup pattern in listen did not reach ready");
  a_pair_not_single: assert property (poc_state_o == 5'h02 && wus_a_i
    && !(gap_ok_a_i && par_a_q) && !par_b_q && !wus_b_i && !wb_cyc_i
    |-> ##2 poc_state_o == 5'h02)
    else $error("single symbol taken as a pattern");
  a_sched_full: assert property ($rose(poc_state_o == 5'h08) |-> $past(tick_q) >= 8'h09)
    else $error("schedule initialisation cut short");
  a_pair_outcome: assert property (pair_end_i && poc_state_o == 5'h04 && tick_q >= 8'h09
    |-> ##2 (poc_state_o == 5'h08 || poc_state_o == 5'h10))
    else $error("cycle pair end gave no outcome");
  a_abort_retry: assert property (poc_state_o == 5'h10 |=> poc_state_o == 5'h04)
    else $error("abort did not return to startup");
  cover property (poc_state_o == 5'h02 ##[1:8] poc_state_o == 5'h01);
  cover property (poc_state_o == 5'h08);
  cover property (poc_state_o == 5'h10);
endmodule // wakeup_poc_ctrl_asserts
bind wakeup_poc_ctrl wakeup_poc_ctrl_asserts asserts_u (.*);
`default_nettype wire

/* File: bus_nodes.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Other nodes on channels A and B
// ****
module bus_nodes #(
  parameter int MT_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output wire logic wus_a_o,
  output wire logic wus_b_o,
  output wire logic gap_ok_a_o,
  output wire logic gap_ok_b_o,
  output wire logic mt_tick_o,
  output wire logic pair_end_o,
  output wire logic [15:0] offset_o
);
  logic [1:0] wus_q = 2'b00;
  logic [1:0] gap_q = 2'b00;
  logic [7:0] mt_cnt_q = 8'h00;
  logic tick_q = 1'b0;
  logic pair_q = 1'b0;
  logic [15:0] ofs_q = 16'h0000;
  assign wus_a_o = wus_q[0];
  assign wus_b_o = wus_q[1];
  assign gap_ok_a_o = gap_q[0];
  assign gap_ok_b_o = gap_q[1];
  assign mt_tick_o = tick_q;
  assign pair_end_o = pair_q;
  assign offset_o = ofs_q;
  always @(posedge clk_i) begin
    if (rst_i) mt_cnt_q <= 8'h00;
    else mt_cnt_q <= (mt_cnt_q == MT_CYC - 1) ? 8'h00 : mt_cnt_q + 8'h01;
    tick_q <= !rst_i && (mt_cnt_q == MT_CYC - 1);
  end
  task automatic send_wus(input int ch, input logic gap);
    wus_q[ch] <= 1'b1;
    gap_q[ch] <= gap;
    @(posedge clk_i);
    wus_q[ch] <= 1'b0;
    // Gap level means nothing between symbols, so it is not left stale
    gap_q[ch] <= ~gap;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic end_pair(input logic [15:0] ofs);
    pair_q <= 1'b1;
    ofs_q <= ofs;
    @(posedge clk_i);
    pair_q <= 1'b0;
    ofs_q <= ~ofs;
    @(posedge clk_i);
  endtask
endmodule // bus_nodes
`default_nettype wire

/* File: wakeup_poc_ctrl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_poc_defines.vh"
// ****
// Register level tests of the wakeup and POC controller
// ****
module wakeup_poc_ctrl_tb_top;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] LOW = 32'h0000_0FFF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o;
  wire logic wus_a_i;
  wire logic wus_b_i;
  wire logic gap_ok_a_i;
  wire logic gap_ok_b_i;
  wire logic mt_tick_i;
  wire logic pair_end_i;
  wire logic [15:0] offset_i;
  wire logic irq_o;
  wire logic [4:0] poc_state_o;
  wire logic [15:0] offset_corr_o;
  logic [31:0] rd_q;
  int n_fail = 0;
  int checks_done = 0;
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  wakeup_poc_ctrl dut_u (.*);
  bus_nodes nodes_u (.clk_i(clk_i), .rst_i(rst_i), .wus_a_o(wus_a_i), .wus_b_o(wus_b_i),
    .gap_ok_a_o(gap_ok_a_i), .gap_ok_b_o(gap_ok_b_i), .mt_tick_o(mt_tick_i),
    .pair_end_o(pair_end_i), .offset_o(offset_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(1'b0, 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] m);
    xfer(1'b0, adr, 32'h0000_0000);
    check(rd_q & m, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clk_i); while (mt_tick_i !== 1'b1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_0101, ALL);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0000, ALL);
    rd_chk(`ADR_IRQ_ENABLE, 32'h0000_0000, ALL);
    rd_chk(`ADR_OFFSET_LIMIT, 32'h0000_0100, ALL);
    rd_chk(8'h18, 32'h0000_0000, ALL);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0004);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0001);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_0001, ALL);
    $display("test reset and ready done");
    xfer(1'b1, `ADR_IRQ_ENABLE, 32'h0000_0008);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0002);
    nodes_u.send_wus(0, 1'b1);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_0002, ALL);
    nodes_u.send_wus(0, 1'b1);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_3101, ALL);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0003, ALL);
    check(irq_o, 1'b0);
    xfer(1'b1, `ADR_IRQ_ENABLE, 32'h0000_001F);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    xfer(1'b1, `ADR_STATUS_CLR, 32'h0000_001F);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    nodes_u.send_wus(0, 1'b1);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0000, ALL);
    nodes_u.send_wus(0, 1'b1);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0002, ALL);
    xfer(1'b1, `ADR_STATUS_CLR, 32'h0000_001F);
    nodes_u.send_wus(0, 1'b1);
    nodes_u.send_wus(1, 1'b1);
    nodes_u.send_wus(0, 1'b0);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0000, ALL);
    nodes_u.send_wus(1, 1'b1);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0004, ALL);
    $display("test wakeup done");
    xfer(1'b1, `ADR_STATUS_CLR, 32'h0000_001F);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0003);
    ticks(10);
    nodes_u.end_pair(16'h0040);
    @(posedge clk_i);
    check(poc_state_o, 5'h08);
    check(offset_corr_o, 16'h0040);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0008, ALL);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0001);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_0101, LOW);
    // Limit equal to one macrotick, below the safe setting
    xfer(1'b1, `ADR_OFFSET_LIMIT, 32'h0000_0040);
    xfer(1'b1, `ADR_STATUS_CLR, 32'h0000_001F);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0003);
    ticks(10);
    nodes_u.end_pair(16'h0040);
    rd_chk(`ADR_STATUS_IRQ, 32'h0000_0010, ALL);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_0104, LOW);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0001);
    rd_chk(`ADR_CTRL_STATUS, 32'h0000_0101, LOW);
    // Abort inside schedule init, then a fresh run must count it in full
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0003);
    ticks(4);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0001);
    xfer(1'b1, `ADR_COMMAND, 32'h0000_0003);
    ticks(7);
    nodes_u.end_pair(16'h0000);
    @(posedge clk_i);
    check(poc_state_o, 5'h04);
    ticks(3);
    nodes_u.end_pair(16'hFFF0);
    @(posedge clk_i);
    check(poc_state_o, 5'h08);
    check(offset_corr_o, 16'hFFF0);
    $display("test integration done");
    conclude();
  end
endmodule // wakeup_poc_ctrl_tb_top
`default_nettype wire
